// ---- sep_regs.vh ----
// constants for the serial eeprom programming control block
`ifndef SEP_REGS_VH
`define SEP_REGS_VH

// ==========================================================
// timing
`define SEP_CLK_KHZ 40000
`define SEP_T_PROG_MS 10
// programming time in system clocks: 10 ms at 40 MHz, sized for the timer
`define SEP_PROG_CYCLES 20'h61a80

// ==========================================================
// opcodes and sub-opcodes
`define SEP_OP_EXT 2'h0
`define SEP_OP_WRITE 2'h1
`define SEP_OP_READ 2'h2
`define SEP_OP_ERASE 2'h3
`define SEP_SUB_LOCK 2'h0
`define SEP_SUB_FILL 2'h1
`define SEP_SUB_WIPE 2'h2
`define SEP_SUB_UNLOCK 2'h3

// ==========================================================
// pulse counts from the start bit to chip select falling
`define SEP_CNT_WR8 5'h12
`define SEP_CNT_WR16 5'h19
`define SEP_CNT_ER8 5'h0a
`define SEP_CNT_ER16 5'h09
`define SEP_CNT_SUB 5'h05
`define SEP_CNT_MAX 5'h1f
`define SEP_OPC_BITS 5'h02
`define SEP_AW8_END 5'h09
`define SEP_AW16_END 5'h08

// ==========================================================
// programming jobs queued for the engine
`define SEP_JOB_WRITE 2'h0
`define SEP_JOB_ERASE 2'h1
`define SEP_JOB_WIPE 2'h2
`define SEP_JOB_FILL 2'h3
`define SEP_JOB_W 26
`define SEP_FIFO_DEPTH 32
`define SEP_FIFO_AW 5

// ==========================================================
// array
`define SEP_MEM_DEPTH 128
`define SEP_MEM_AW 7
`define SEP_ERASED 8'hff
`define SEP_LAST_BYTE 7'h7f

`endif

// ---- sep_fifo.v ----
// job fifo between the serial front end and the programming engine
`timescale 1ns/1ps
module sep_fifo #(
  parameter W = 26,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire sys_clk,
  input wire rst,
  input wire inValid,
  output wire inReady,
  input wire [W-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [W-1:0] outData
);
  reg [W-1:0] store [0:DEPTH-1];
  reg [AW:0] wrPtr;
  reg [AW:0] rdPtr;
  wire empty = (wrPtr == rdPtr);
  wire full = (wrPtr[AW-1:0] == rdPtr[AW-1:0]) && (wrPtr[AW] != rdPtr[AW]);
  wire doPush = inValid & ~full;
  wire doPop = outReady & ~empty;

  assign inReady = ~full;
  assign outValid = ~empty;
  assign outData = store[rdPtr[AW-1:0]];

  // ==========================================================
  // storage
  always @(posedge sys_clk) begin
    if (doPush) begin
      store[wrPtr[AW-1:0]] <= inData;
    end
  end

  // ==========================================================
  // pointers
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPtr <= {(AW+1){1'b0}};
      rdPtr <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end
endmodule

// ---- sep_mem.v ----
// byte array of the eeprom with a registered read port
`timescale 1ns/1ps
`include "sep_regs.vh"
module sep_mem (
  input wire sys_clk,
  input wire rdEn,
  input wire [`SEP_MEM_AW-1:0] rdAddr,
  output reg [7:0] rdData,
  input wire wrEn,
  input wire [`SEP_MEM_AW-1:0] wrAddr,
  input wire [7:0] wrData
);
  reg [7:0] cells [0:`SEP_MEM_DEPTH-1];
  integer i;

  // delivered content is all ones
  initial begin
    for (i = 0; i < `SEP_MEM_DEPTH; i = i + 1) begin
      cells[i] = `SEP_ERASED;
    end
  end

  always @(posedge sys_clk) begin
    if (wrEn) begin
      cells[wrAddr] <= wrData;
    end
    if (rdEn) begin
      rdData <= cells[rdAddr];
    end
  end
endmodule

// ---- sep_prog_ctrl.v ----
// serial eeprom instruction front end and self-timed programming engine
`timescale 1ns/1ps
`include "sep_regs.vh"
// Contract
// - write carries one byte (x8) or one word (x16) of data to program
// - serial input is sampled on each rising serial clock edge; the code ignores edges while progBusy is high
// - busy shows as 0 on serial output while select is high
// - ready shows as 1 until new start bit or select low
// - write erases its location itself before programming
// - wipe_array sets every bit of the array to 1 on select fall
// - fill_array ANDs its data into every address, no erase
// - status appears only after programming instructions, select high
// - enhanced variant counts clock pulses from start bit to select fall
// - enhanced x8 write needs exactly 18 pulses, else discarded
// - enhanced x16 write needs exactly 25 pulses, else discarded
// - count check covers only write, erase, wipe and fill
// - array starts all ones
// - instruction opens with select high then a start bit of 1
// - opcode 01 write, 10 read, 11 erase, 00 uses sub-opcode
// - width select low means x8, high means x16
// - programming needs unlock; lock or reset blocks it again
module sep_prog_ctrl #(
  parameter [19:0] PROG_CYCLES = `SEP_PROG_CYCLES
) (
  input wire sys_clk,
  input wire rst,
  input wire chipSelect,
  input wire serialClock,
  input wire serialIn,
  input wire widthSelect,
  input wire enhancedMode,
  output reg serialOut,
  output reg serialOutEn,
  output wire progBusy
);
  localparam [3:0] E_IDLE = 4'h1;
  localparam [3:0] E_READ = 4'h2;
  localparam [3:0] E_WRITE = 4'h4;
  localparam [3:0] E_WAIT = 4'h8;

  // ==========================================================
  // decoding helpers
  function [1:0] subOp;
    input [6:0] a;
    input w;
    begin
      subOp = w ? a[5:4] : a[6:5];
    end
  endfunction

  // pulses a programming instruction must carry; zero if not one
  function [4:0] needCount;
    input [1:0] op;
    input [1:0] sub;
    input w;
    begin
      needCount = 5'h00;
      if (op == `SEP_OP_WRITE ||
          (op == `SEP_OP_EXT && sub == `SEP_SUB_FILL)) begin
        needCount = w ? `SEP_CNT_WR16 : `SEP_CNT_WR8;
      end else if (op == `SEP_OP_ERASE ||
                   (op == `SEP_OP_EXT && sub == `SEP_SUB_WIPE)) begin
        needCount = w ? `SEP_CNT_ER16 : `SEP_CNT_ER8;
      end
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  reg csMeta, csSync, csLast;
  reg clkMeta, clkSync, clkLast;
  reg dinMeta, dinSync;
  reg orgMeta, orgSync;
  reg enhMeta, enhSync;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      csMeta <= 1'b0;
      csSync <= 1'b0;
      csLast <= 1'b0;
      clkMeta <= 1'b0;
      clkSync <= 1'b0;
      clkLast <= 1'b0;
      dinMeta <= 1'b0;
      dinSync <= 1'b0;
      orgMeta <= 1'b1;
      orgSync <= 1'b1;
      enhMeta <= 1'b0;
      enhSync <= 1'b0;
    end else begin
      csMeta <= chipSelect;
      csSync <= csMeta;
      csLast <= csSync;
      clkMeta <= serialClock;
      clkSync <= clkMeta;
      clkLast <= clkSync;
      dinMeta <= serialIn;
      dinSync <= dinMeta;
      orgMeta <= widthSelect;
      orgSync <= orgMeta;
      enhMeta <= enhancedMode;
      enhSync <= enhMeta;
    end
  end

  wire clkRise = clkSync & ~clkLast;
  wire csFall = ~csSync & csLast;

  // ==========================================================
  // serial front end
  reg started;
  reg [4:0] pulseCount;
  reg [1:0] opcode;
  reg [6:0] addr;
  reg [15:0] dataWord;
  reg wide;
  reg enhanced;
  reg unlocked;
  reg statusMode;
  wire busy;
  wire jobReady;
  reg jobValid;
  reg [`SEP_JOB_W-1:0] jobIn;

  wire [4:0] addrEnd = wide ? `SEP_AW16_END : `SEP_AW8_END;
  wire [1:0] curSub = subOp(addr, wide);
  wire [4:0] need = needCount(opcode, curSub, wide);
  wire isProg = (need != 5'h00);
  wire countOk = enhanced ? (pulseCount == need) :
                 (pulseCount >= need);
  wire isExtCtl = (opcode == `SEP_OP_EXT) &&
                  (curSub == `SEP_SUB_UNLOCK || curSub == `SEP_SUB_LOCK);
  reg [1:0] jobKind;

  always @* begin
    jobKind = `SEP_JOB_WRITE;
    if (opcode == `SEP_OP_ERASE) begin
      jobKind = `SEP_JOB_ERASE;
    end else if (opcode == `SEP_OP_EXT) begin
      jobKind = (curSub == `SEP_SUB_WIPE) ? `SEP_JOB_WIPE : `SEP_JOB_FILL;
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      started <= 1'b0;
      pulseCount <= 5'h00;
      opcode <= 2'h0;
      addr <= 7'h00;
      dataWord <= 16'h0000;
      wide <= 1'b1;
      enhanced <= 1'b0;
      unlocked <= 1'b0;
      statusMode <= 1'b0;
      jobValid <= 1'b0;
      jobIn <= {`SEP_JOB_W{1'b0}};
    end else begin
      jobValid <= 1'b0;
      if (!csSync) begin
        started <= 1'b0;
        pulseCount <= 5'h00;
      end else if (clkRise && !busy) begin
        if (!started) begin
          if (dinSync) begin
            started <= 1'b1;
            pulseCount <= 5'h01;
            wide <= orgSync;
            enhanced <= enhSync;
            statusMode <= 1'b0;
          end
        end else begin
          if (pulseCount != `SEP_CNT_MAX) begin
            pulseCount <= pulseCount + 5'h01;
          end
          // each bit lands in its field by position
          if (pulseCount <= `SEP_OPC_BITS) begin
            opcode <= {opcode[0], dinSync};
          end else if (pulseCount <= addrEnd) begin
            addr <= {addr[5:0], dinSync};
          end else begin
            dataWord <= {dataWord[14:0], dinSync};
          end
        end
      end
      // select falling closes the instruction
      if (csFall && started) begin
        if (isExtCtl && pulseCount >= `SEP_CNT_SUB) begin
          unlocked <= (curSub == `SEP_SUB_UNLOCK);
        end
        if (isProg && countOk && unlocked && jobReady) begin
          jobValid <= 1'b1;
          jobIn <= {jobKind, wide, addr, dataWord};
          statusMode <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // job queue
  wire qValid;
  wire qReady;
  wire [`SEP_JOB_W-1:0] qData;

  sep_fifo #(
    .W(`SEP_JOB_W),
    .DEPTH(`SEP_FIFO_DEPTH),
    .AW(`SEP_FIFO_AW)
  ) jobQueue (
    .sys_clk(sys_clk),
    .rst(rst),
    .inValid(jobValid),
    .inReady(jobReady),
    .inData(jobIn),
    .outValid(qValid),
    .outReady(qReady),
    .outData(qData)
  );

  // ==========================================================
  // programming engine
  reg [3:0] engState;
  reg [1:0] curKind;
  reg curWide;
  reg [15:0] curData;
  reg [6:0] ptr;
  reg [6:0] endPtr;
  reg [19:0] timer;
  wire [7:0] rdData;
  reg memWe;
  reg [7:0] memWd;
  reg [7:0] srcByte;

  assign qReady = engState[0];
  assign busy = qValid | ~engState[0];
  assign progBusy = busy;

  wire [1:0] qKind = qData[25:24];
  wire qWide = qData[23];
  wire [6:0] qAddr = qData[22:16];

  always @* begin
    srcByte = curData[7:0];
    if (curWide && !ptr[0]) begin
      srcByte = curData[15:8];
    end
    memWe = engState[2];
    case (curKind)
      `SEP_JOB_WRITE: memWd = srcByte;
      `SEP_JOB_FILL: memWd = rdData & srcByte;
      default: memWd = `SEP_ERASED;
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      engState <= E_IDLE;
      curKind <= `SEP_JOB_WRITE;
      curWide <= 1'b0;
      curData <= 16'h0000;
      ptr <= 7'h00;
      endPtr <= 7'h00;
      timer <= 20'h00000;
    end else begin
      case (engState)
        E_IDLE: begin
          if (qValid) begin
            curKind <= qKind;
            curWide <= qWide;
            curData <= qData[15:0];
            engState <= E_READ;
            if (qKind == `SEP_JOB_WIPE || qKind == `SEP_JOB_FILL) begin
              ptr <= 7'h00;
              endPtr <= `SEP_LAST_BYTE;
            end else if (qWide) begin
              ptr <= {qAddr[5:0], 1'b0};
              endPtr <= {qAddr[5:0], 1'b1};
            end else begin
              ptr <= qAddr;
              endPtr <= qAddr;
            end
          end
        end
        E_READ: begin
          engState <= E_WRITE;
        end
        E_WRITE: begin
          if (ptr == endPtr) begin
            timer <= 20'h00000;
            engState <= E_WAIT;
          end else begin
            ptr <= ptr + 7'h01;
            engState <= E_READ;
          end
        end
        E_WAIT: begin
          if (timer >= PROG_CYCLES - 20'h00001) begin
            engState <= E_IDLE;
          end else begin
            timer <= timer + 20'h00001;
          end
        end
        default: begin
          engState <= E_IDLE;
        end
      endcase
    end
  end

  sep_mem array (
    .sys_clk(sys_clk),
    .rdEn(engState[1]),
    .rdAddr(ptr),
    .rdData(rdData),
    .wrEn(memWe),
    .wrAddr(ptr),
    .wrData(memWd)
  );

  // ==========================================================
  // ready/busy on the serial output
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      serialOut <= 1'b1;
      serialOutEn <= 1'b0;
    end else begin
      serialOut <= ~busy;
      serialOutEn <= csSync & statusMode;
    end
  end
endmodule

// ---- sep_unused_placeholder_none.v ----
// intentionally empty file: no modules
`timescale 1ns/1ps

// ---- sep_prog_ctrl_asserts.sv ----
// concurrent checks on the ports of the programming control block
`timescale 1ns/1ps
module sep_prog_ctrl_asserts #(
  parameter [19:0] PROG_CYCLES = 20'h00014
) (
  input wire sys_clk,
  input wire rst,
  input wire chipSelect,
  input wire serialClock,
  input wire serialIn,
  input wire widthSelect,
  input wire enhancedMode,
  input wire serialOut,
  input wire serialOutEn,
  input wire progBusy
);
  reg [9:0] busyLen;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // busy length counter
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      busyLen <= 10'h000;
    else if (!progBusy)
      busyLen <= 10'h000;
    else if (busyLen != 10'h3ff)
      busyLen <= busyLen + 10'h001;
  end
  // ==========================================================
  // properties
  reset_vals_a: assert property (disable iff (1'b0)
    rst |-> serialOut && !serialOutEn && !progBusy)
    else $error("outputs wrong during reset");
  busy_q_low_a: assert property (
    serialOutEn && progBusy && $past(progBusy) |-> !serialOut)
    else $error("serial output not busy while programming");
  ready_q_high_a: assert property (
    serialOutEn && !progBusy && !$past(progBusy) && !$past(progBusy, 2)
    |-> serialOut)
    else $error("serial output not ready after programming");
  en_off_a: assert property (
    !chipSelect [*5] |=> !serialOutEn)
    else $error("output enable high without select");
  en_follows_cs_a: assert property (
    $rose(serialOutEn) |-> chipSelect && $past(chipSelect))
    else $error("output enable rose without select");
  start_on_fall_a: assert property (
    $rose(progBusy) |-> !chipSelect && !$past(chipSelect, 2))
    else $error("programming started without select fall");
  busy_holds_a: assert property (
    $rose(progBusy) |-> progBusy [*8])
    else $error("busy dropped early");
  busy_len_a: assert property (
    $fell(progBusy) |-> {10'h000, busyLen} >= PROG_CYCLES)
    else $error("programming cycle too short");
endmodule
bind sep_prog_ctrl sep_prog_ctrl_asserts #(.PROG_CYCLES(PROG_CYCLES))
  i_sep_prog_ctrl_asserts (.sys_clk(sys_clk), .rst(rst),
  .chipSelect(chipSelect), .serialClock(serialClock),
  .serialIn(serialIn), .widthSelect(widthSelect),
  .enhancedMode(enhancedMode), .serialOut(serialOut),
  .serialOutEn(serialOutEn), .progBusy(progBusy));

// ---- sep_host.sv ----
// host model driving select, serial clock and serial data
`timescale 1ns/1ps
module sep_host (
  input wire sys_clk,
  output reg chipSelect,
  output reg serialClock,
  output reg serialIn
);
  initial begin
    chipSelect = 1'b0;
    serialClock = 1'b0;
    serialIn = 1'b0;
  end
  // each clock phase lasts four system clocks
  task phase;
    begin
      repeat (4) @(posedge sys_clk);
      #2;
    end
  endtask
  // data stays parked so a shared data wire is never fought over
  task hold(input v);
    chipSelect = v;
  endtask
  // bits go out msb first, start bit included
  task send(input [31:0] bits, input integer n);
    integer i;
    begin
      chipSelect = 1'b1;
      for (i = n - 1; i >= 0; i = i - 1) begin
        serialIn = bits[i];
        phase;
        serialClock = 1'b1;
        phase;
        serialClock = 1'b0;
      end
      phase;
      chipSelect = 1'b0;
      serialIn = ~serialIn;
    end
  endtask
endmodule

// ---- serial_eeprom_program_control_test.sv ----
// self-checking bench for the programming control block
`timescale 1ns/1ps
module serial_eeprom_program_control_test;
  localparam [19:0] PROG = 20'h00014;
  localparam [31:0] RD = {22'h0, 1'b1, 2'h2, 7'h05};
  localparam [31:0] W8 = {14'h0, 1'b1, 2'h1, 7'h05, 8'ha5};
  localparam [31:0] W16 = {7'h0, 1'b1, 2'h1, 6'h03, 16'h1234};
  localparam [31:0] UNL = {22'h0, 1'b1, 2'h0, 2'h3, 5'h00};
  localparam [31:0] LCK = {22'h0, 1'b1, 2'h0, 2'h0, 5'h00};
  localparam [31:0] ERS = {22'h0, 1'b1, 2'h3, 7'h05};
  localparam [31:0] WIPE = {22'h0, 1'b1, 2'h0, 2'h2, 5'h00};
  localparam [31:0] FILL = {14'h0, 1'b1, 2'h0, 2'h1, 5'h00, 8'h3c};
  reg sys_clk;
  reg rst;
  reg widthSelect;
  reg enhancedMode;
  wire chipSelect, serialClock, serialIn, serialOut, serialOutEn, progBusy;
  integer num_errors, compares, cycles;
  sep_prog_ctrl #(.PROG_CYCLES(PROG)) i_sep_prog_ctrl (.sys_clk(sys_clk),
    .rst(rst), .chipSelect(chipSelect), .serialClock(serialClock),
    .serialIn(serialIn), .widthSelect(widthSelect),
    .enhancedMode(enhancedMode), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .progBusy(progBusy));
  sep_host i_sep_host (.sys_clk(sys_clk), .chipSelect(chipSelect),
    .serialClock(serialClock), .serialIn(serialIn));
  // ==========================================================
  // helpers
  task cyc(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #2;
    end
  endtask
  task check(input [63:0] name, input got, input exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0s expected %b seen %b", name, exp, got);
      end
    end
  endtask
  task checkByte(input [6:0] a, input [7:0] exp);
    begin
      compares = compares + 1;
      if (i_sep_prog_ctrl.array.cells[a] !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] cell %0d expected %h seen %h", a, exp,
          i_sep_prog_ctrl.array.cells[a]);
      end
    end
  endtask
  task stop_test;
    begin
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // spent counts busy cycles the caller already let pass
  task waitIdle(input integer bytes, input integer spent);
    integer len;
    begin
      len = spent;
      while (progBusy === 1'b1 && len < 400) begin
        cyc(1);
        len = len + 1;
      end
      check("busylen", len >= bytes * 2 + PROG - 4 &&
        len <= bytes * 2 + PROG + 4, 1'b1);
    end
  endtask
  task instr(input [31:0] bits, input integer n, input wide, input enh,
    input expBusy, input integer bytes);
    begin
      widthSelect = wide;
      enhancedMode = enh;
      cyc(4);
      i_sep_host.send(bits, n);
      cyc(6);
      check("busy", progBusy, expBusy);
      if (expBusy)
        waitIdle(bytes, 0);
    end
  endtask
  // ==========================================================
  // scenarios
  task t_locked;
    begin
      instr(W8, 18, 1'b0, 1'b1, 1'b0, 1);
      checkByte(7'h05, 8'hff);
    end
  endtask
  task t_write;
    begin
      instr(UNL, 10, 1'b0, 1'b1, 1'b0, 0);
      instr(W8, 18, 1'b0, 1'b1, 1'b1, 1);
      checkByte(7'h05, 8'ha5);
    end
  endtask
  task t_status;
    begin
      cyc(4);
      i_sep_host.send(W8, 18);
      cyc(6);
      i_sep_host.hold(1'b1);
      cyc(5);
      check("q_en", serialOutEn, 1'b1);
      check("q_busy", serialOut, 1'b0);
      waitIdle(1, 5);
      cyc(3);
      check("q_ready", serialOut, 1'b1);
      i_sep_host.hold(1'b0);
      cyc(6);
      check("q_off", serialOutEn, 1'b0);
    end
  endtask
  task t_count;
    begin
      instr({W8[30:0], 1'b0}, 19, 1'b0, 1'b1, 1'b0, 1);
      checkByte(7'h05, 8'ha5);
      instr(W16, 25, 1'b1, 1'b1, 1'b1, 2);
      checkByte(7'h06, 8'h12);
      checkByte(7'h07, 8'h34);
      instr(W16 >> 1, 24, 1'b1, 1'b1, 1'b0, 2);
      checkByte(7'h07, 8'h34);
      instr({W8[30:0], 1'b0}, 19, 1'b0, 1'b0, 1'b1, 1);
      checkByte(7'h05, 8'h4a);
    end
  endtask
  task t_bulk;
    begin
      instr(ERS, 10, 1'b0, 1'b1, 1'b1, 1);
      checkByte(7'h05, 8'hff);
      instr(WIPE, 10, 1'b0, 1'b1, 1'b1, 128);
      checkByte(7'h07, 8'hff);
      instr(FILL, 18, 1'b0, 1'b1, 1'b1, 128);
      checkByte(7'h00, 8'h3c);
      checkByte(7'h7f, 8'h3c);
    end
  endtask
  task t_lock;
    begin
      instr(RD, 10, 1'b0, 1'b1, 1'b0, 0);
      instr(LCK, 10, 1'b0, 1'b1, 1'b0, 0);
      instr(W8, 18, 1'b0, 1'b1, 1'b0, 1);
      checkByte(7'h05, 8'h3c);
    end
  endtask
  // ==========================================================
  // clock, timeout and main sequence
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      stop_test;
    end
  end
  initial begin
    num_errors = 0;
    compares = 0;
    cycles = 0;
    rst = 1'b1;
    widthSelect = 1'b0;
    enhancedMode = 1'b1;
    cyc(5);
    rst = 1'b0;
    cyc(4);
    t_locked;
    t_write;
    t_status;
    t_count;
    t_bulk;
    t_lock;
    stop_test;
  end
endmodule
